/* src/ebcc_ctrl.sv */
// External bus cycle control: strobes, enables, direction, termination and sizing.
// ==========================================================
// Notes on behaviour
// R1: In SRAM and peripheral cycles a byte-lane strobe goes low for each byte to be moved.
// R2: Only the lanes used by the current beat are strobed; the others stay negated.
// R3: The lower strobe covers the least significant byte lane, the upper one the most.
// R4: Strobes show on the pins for on-chip peripheral cycles but not for on-chip memory.
// R5: In SDRAM cycles the strobes act as column strobes, high for a lane that transfers.
// R6: Output enable is low during external reads, while the slave may drive the data bus.
// R7: The slave acknowledges a beat; on a read the data is captured, then the cycle ends.
// R8: An acknowledge during a write simply ends the cycle.
// R9: An error acknowledge ends the cycle and raises an access error to the core.
// R10: The direction output is high for reads and low for writes, SRAM and SDRAM alike.
// R11: Each chip select has its own port width of 8, 16 or 32 bits.
// R12: The boot chip select width is taken from the size pins after reset.
// R13: Software sets the widths of the other chip selects before using their spaces.
// R14: A one-cycle transfer start pulse marks the beginning of every bus beat; the code pulses it for external beats only, not for peripheral beats.
// R15: Eight chip-select outputs pick the slave; two of them may serve SDRAM.
// R16: An external beat holds, with wait cycles, until either acknowledge is seen.
// R17: An access wider than its port is split into successive beats.
`timescale 1ns/100ps

module ebcc_ctrl
    import ebcc_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic REQ_VALID,
    input wire logic REQ_READ,
    input wire logic [1:0] REQ_SIZE,
    input wire logic [1:0] REQ_OFFSET,
    input wire logic [2:0] REQ_CS,
    input wire logic [1:0] REQ_TARGET,
    input wire logic REQ_SDRAM,
    input wire logic [31:0] REQ_WDATA,
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic RSP_ERROR,
    output logic [31:0] RSP_RDATA,
    output logic ACCESS_ERROR,
    input wire logic WIDTH_LOAD,
    input wire logic [2:0] WIDTH_CS,
    input wire logic [1:0] WIDTH_CODE,
    input wire logic [1:0] TRANSFER_SIZE_PINS,
    input wire logic CYCLE_DONE_ACK_N,
    input wire logic CYCLE_ERROR_ACK_N,
    input wire logic [31:0] DATA_IN,
    output logic [31:0] DATA_OUT,
    output logic DATA_OE,
    output logic TRANSFER_BEGIN_N,
    output logic [7:0] CHIP_SELECT_N,
    output logic [1:0] BYTE_LANE_STROBE_N,
    output logic OUTPUT_ENABLE_N,
    output logic READ_WRITE,
    output logic SDRAM_WRITE_STROBE
);

    // ==========================================================
    // Pin synchronisers.
    logic done_s1_reg;
    logic done_s2_reg;
    logic err_s1_reg;
    logic err_s2_reg;
    logic [1:0] tsz_s1_reg;
    logic [1:0] tsz_s2_reg;
    logic [31:0] din_s1_reg;
    logic [31:0] din_s2_reg;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            done_s1_reg <= 1'b1;
            done_s2_reg <= 1'b1;
            err_s1_reg <= 1'b1;
            err_s2_reg <= 1'b1;
            tsz_s1_reg <= EBCC_W32;
            tsz_s2_reg <= EBCC_W32;
            din_s1_reg <= '0;
            din_s2_reg <= '0;
        end else begin
            done_s1_reg <= CYCLE_DONE_ACK_N;
            done_s2_reg <= done_s1_reg;
            err_s1_reg <= CYCLE_ERROR_ACK_N;
            err_s2_reg <= err_s1_reg;
            tsz_s1_reg <= TRANSFER_SIZE_PINS;
            tsz_s2_reg <= tsz_s1_reg;
            din_s1_reg <= DATA_IN;
            din_s2_reg <= din_s1_reg;
        end
    end

    // ==========================================================
    // Boot width strap. The pins are sampled only once the synchroniser
    // holds post-reset values, never under the asynchronous reset itself.
    logic [1:0] strap_cnt_reg;
    logic strap_done_reg;
    logic strap_load;

    assign strap_load = !strap_done_reg && (strap_cnt_reg == EBCC_STRAP_SETTLE);

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            strap_cnt_reg <= '0;
            strap_done_reg <= 1'b0;
        end else if (strap_load) begin
            strap_done_reg <= 1'b1;
        end else if (!strap_done_reg) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
        end
    end

    // ==========================================================
    // Width table, one entry per chip select.
    logic [1:0] width_reg [EBCC_NUM_CS];

    generate
        for (genvar i = 0; i < EBCC_NUM_CS; i++) begin : g_width
            always_ff @(posedge MCLK or negedge RESETN) begin
                if (!RESETN) begin
                    width_reg[i] <= EBCC_W32;
                end else if (i == 0 && strap_load) begin
                    width_reg[i] <= tsz_s2_reg; // [R12]
                end else if (WIDTH_LOAD && WIDTH_CS == 3'(i)) begin
                    width_reg[i] <= WIDTH_CODE; // [R11]
                end
            end
        end
    endgenerate

    // ==========================================================
    // Beat geometry.
    ebcc_state_type state_reg;
    logic ready_reg;
    logic rd_reg;
    logic sd_reg;
    logic [2:0] cs_reg;
    logic [1:0] tgt_reg;
    logic [2:0] port_reg;
    logic [2:0] left_reg;
    logic [1:0] off_reg;
    logic [31:0] sh_reg;
    logic [31:0] acc_reg;
    logic [1:0] guard_reg;

    logic take;
    logic launch;
    logic ext;
    logic ack_seen;
    logic err_seen;
    logic finish;
    logic last_beat;
    logic [2:0] beat_bytes;
    logic [2:0] req_bytes;
    logic [1:0] port_lsb_mask;
    logic [1:0] lane_pos;
    logic [3:0] lane_mask;
    logic [1:0] lane_use;
    logic [4:0] pos_bits;
    logic [5:0] beat_bits;
    logic [31:0] piece;

    assign take = (state_reg == EBCC_IDLE) && REQ_VALID && ready_reg;
    assign launch = (state_reg == EBCC_START);
    assign ext = (tgt_reg == EBCC_TGT_EXT);
    assign err_seen = ext && !err_s2_reg;
    // On-chip targets answer internally; external beats wait for the slave.
    assign ack_seen = !ext || !done_s2_reg || err_seen;
    assign finish = (state_reg == EBCC_WAIT) && (guard_reg == EBCC_ACK_GUARD)
        && ack_seen; // [R16]
    assign req_bytes = ebcc_bytes(REQ_SIZE);
    assign beat_bytes = (left_reg < port_reg) ? left_reg : port_reg; // [R17]
    assign last_beat = (left_reg == beat_bytes);
    assign port_lsb_mask = port_reg[1:0] - 2'h1;
    assign lane_pos = off_reg & port_lsb_mask;
    assign pos_bits = {lane_pos, 3'h0};
    assign beat_bits = {beat_bytes, 3'h0};
    assign lane_mask = ((beat_bytes == EBCC_BYTES1) ? EBCC_MASK1 :
        (beat_bytes == EBCC_BYTES2) ? EBCC_MASK2 : EBCC_MASK4) >> lane_pos; // [R2]
    assign piece = (din_s2_reg << pos_bits) >> (EBCC_BUS_BITS - beat_bits);

    // Lane 3 is the most significant byte; each strobe covers the matching
    // byte of both halfwords, as only two strobe pins exist.
    generate
        for (genvar j = 0; j < 2; j++) begin : g_lane
            assign lane_use[j] = lane_mask[j + 2] | lane_mask[j]; // [R3]
        end
    endgenerate

    // ==========================================================
    // Sequencer.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= EBCC_IDLE;
            ready_reg <= 1'b0;
            guard_reg <= '0;
        end else begin
            unique case (state_reg)
                EBCC_IDLE: begin
                    if (take) begin
                        ready_reg <= 1'b0;
                        state_reg <= EBCC_START;
                    end else begin
                        ready_reg <= strap_done_reg;
                    end
                end
                EBCC_START: begin
                    guard_reg <= '0;
                    state_reg <= EBCC_WAIT;
                end
                EBCC_WAIT: begin
                    if (guard_reg != EBCC_ACK_GUARD) begin
                        guard_reg <= guard_reg + 2'h1;
                    end else if (finish) begin
                        if (err_seen || last_beat) begin // [R9]
                            state_reg <= EBCC_IDLE;
                            ready_reg <= 1'b1;
                        end else begin
                            state_reg <= EBCC_START; // [R17]
                        end
                    end
                end
                default: begin
                    state_reg <= EBCC_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Operand and beat bookkeeping.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_reg <= 1'b1;
            sd_reg <= 1'b0;
            cs_reg <= '0;
            tgt_reg <= EBCC_TGT_EXT;
            port_reg <= EBCC_BYTES4;
            left_reg <= EBCC_BYTES4;
            off_reg <= '0;
            sh_reg <= '0;
            acc_reg <= '0;
        end else if (take) begin
            rd_reg <= REQ_READ;
            sd_reg <= REQ_SDRAM;
            cs_reg <= REQ_CS;
            tgt_reg <= REQ_TARGET;
            port_reg <= (REQ_TARGET == EBCC_TGT_EXT) ? ebcc_bytes(width_reg[REQ_CS])
                : EBCC_BYTES4; // [R11]
            left_reg <= req_bytes;
            off_reg <= REQ_OFFSET;
            sh_reg <= REQ_WDATA << (EBCC_BUS_BITS - {req_bytes, 3'h0});
            acc_reg <= '0;
        end else if (finish) begin
            left_reg <= left_reg - beat_bytes;
            off_reg <= off_reg + beat_bytes[1:0];
            sh_reg <= sh_reg << beat_bits;
            if (rd_reg && ext) begin
                acc_reg <= (acc_reg << beat_bits) | piece; // [R7]
            end
        end
    end

    // ==========================================================
    // Bus pins. Every pin is a flop so the outputs never glitch.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            TRANSFER_BEGIN_N <= 1'b1;
            CHIP_SELECT_N <= EBCC_CS_IDLE;
            BYTE_LANE_STROBE_N <= EBCC_STB_IDLE;
            OUTPUT_ENABLE_N <= 1'b1;
            READ_WRITE <= 1'b1;
            SDRAM_WRITE_STROBE <= 1'b1;
            DATA_OE <= 1'b0;
            DATA_OUT <= '0;
        end else if (launch) begin
            TRANSFER_BEGIN_N <= !ext; // [R14]
            CHIP_SELECT_N <= ext ? ~(EBCC_CS_ONE << cs_reg) : EBCC_CS_IDLE; // [R15]
            if (tgt_reg >= EBCC_TGT_ONCHIP) begin
                BYTE_LANE_STROBE_N <= EBCC_STB_IDLE; // [R4]
            end else if (sd_reg) begin
                BYTE_LANE_STROBE_N <= lane_use; // [R5]
            end else begin
                BYTE_LANE_STROBE_N <= ~lane_use; // [R1] [R4]
            end
            OUTPUT_ENABLE_N <= !(ext && rd_reg); // [R6]
            READ_WRITE <= rd_reg; // [R10]
            SDRAM_WRITE_STROBE <= sd_reg ? rd_reg : 1'b1; // [R10]
            DATA_OE <= ext && !rd_reg;
            DATA_OUT <= sh_reg >> pos_bits;
        end else begin
            TRANSFER_BEGIN_N <= 1'b1;
            if (finish) begin
                CHIP_SELECT_N <= EBCC_CS_IDLE; // [R8]
                BYTE_LANE_STROBE_N <= EBCC_STB_IDLE;
                OUTPUT_ENABLE_N <= 1'b1;
                READ_WRITE <= 1'b1;
                SDRAM_WRITE_STROBE <= 1'b1;
                DATA_OE <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Answers to the core. An error abandons any remaining beats.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            RSP_VALID <= 1'b0;
            RSP_ERROR <= 1'b0;
            RSP_RDATA <= '0;
            ACCESS_ERROR <= 1'b0;
        end else begin
            RSP_VALID <= finish && (err_seen || last_beat);
            ACCESS_ERROR <= finish && err_seen; // [R9]
            if (finish && (err_seen || last_beat)) begin
                RSP_ERROR <= err_seen;
                RSP_RDATA <= (rd_reg && ext && !err_seen)
                    ? ((acc_reg << beat_bits) | piece) : '0; // [R7]
            end
        end
    end

    assign REQ_READY = ready_reg;

endmodule // ebcc_ctrl

/* src/ebcc_pkg.sv */
// Shared constants and types of the external bus cycle control block.
package ebcc_pkg;

    // ==========================================================
    // Port width codes, shared by the size pins and the width table.
    localparam logic [1:0] EBCC_W32 = 2'h0;
    localparam logic [1:0] EBCC_W8 = 2'h1;
    localparam logic [1:0] EBCC_W16 = 2'h2;

    // ==========================================================
    // Access targets.
    localparam logic [1:0] EBCC_TGT_EXT = 2'h0;
    localparam logic [1:0] EBCC_TGT_PERIPH = 2'h1;
    localparam logic [1:0] EBCC_TGT_ONCHIP = 2'h2;

    // ==========================================================
    // Geometry, idle levels and timing counts.
    localparam int EBCC_NUM_CS = 8;
    localparam logic [2:0] EBCC_BYTES1 = 3'h1;
    localparam logic [2:0] EBCC_BYTES2 = 3'h2;
    localparam logic [2:0] EBCC_BYTES4 = 3'h4;
    localparam logic [3:0] EBCC_MASK1 = 4'h8;
    localparam logic [3:0] EBCC_MASK2 = 4'hc;
    localparam logic [3:0] EBCC_MASK4 = 4'hf;
    localparam logic [5:0] EBCC_BUS_BITS = 6'h20;
    localparam logic [7:0] EBCC_CS_IDLE = 8'hff;
    localparam logic [7:0] EBCC_CS_ONE = 8'h01;
    localparam logic [1:0] EBCC_STB_IDLE = 2'h3;
    localparam logic [1:0] EBCC_ACK_GUARD = 2'h2;
    localparam logic [1:0] EBCC_STRAP_SETTLE = 2'h2;

    typedef enum logic [1:0] {
        EBCC_IDLE = 2'b00,
        EBCC_START = 2'b01,
        EBCC_WAIT = 2'b10
    } ebcc_state_type;

    function automatic logic [2:0] ebcc_bytes(input logic [1:0] code);
        if (code == EBCC_W8) begin
            return EBCC_BYTES1;
        end else if (code == EBCC_W16) begin
            return EBCC_BYTES2;
        end
        return EBCC_BYTES4;
    endfunction

endpackage

/* verif/ebcc_ctrl_sva.sv */
// Assertion checker for the external bus cycle control ports.
`timescale 1ns/100ps
module ebcc_ctrl_sva
    import ebcc_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic REQ_VALID,
    input wire logic REQ_READY,
    input wire logic [1:0] REQ_TARGET,
    input wire logic REQ_SDRAM,
    input wire logic RSP_VALID,
    input wire logic RSP_ERROR,
    input wire logic ACCESS_ERROR,
    input wire logic CYCLE_DONE_ACK_N,
    input wire logic CYCLE_ERROR_ACK_N,
    input wire logic TRANSFER_BEGIN_N,
    input wire logic [7:0] CHIP_SELECT_N,
    input wire logic [1:0] BYTE_LANE_STROBE_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic READ_WRITE
);
    // ==========================================================
    // Properties.
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    property p_begin; !TRANSFER_BEGIN_N |=> TRANSFER_BEGIN_N; endproperty
    a_begin: assert property (p_begin) else $error("start pulse too long");
    property p_cs; !TRANSFER_BEGIN_N |-> $onehot(~CHIP_SELECT_N); endproperty
    a_cs: assert property (p_cs) else $error("start without one select");
    property p_oe; !OUTPUT_ENABLE_N |-> READ_WRITE && CHIP_SELECT_N != EBCC_CS_IDLE; endproperty
    a_oe: assert property (p_oe) else $error("output enable outside read");
    // Acknowledges pass two sync flops, so the pin sampled one edge back
    // decides whether the beat may end at the next edge.
    property p_hold;
        CHIP_SELECT_N != EBCC_CS_IDLE && $past(CYCLE_DONE_ACK_N, 1)
            && $past(CYCLE_ERROR_ACK_N, 1) |=> $stable(CHIP_SELECT_N);
    endproperty
    a_hold: assert property (p_hold) else $error("beat ended without ack");
    property p_end;
        (CHIP_SELECT_N != EBCC_CS_IDLE && !CYCLE_DONE_ACK_N) [*3] |-> ##[0:3]
            CHIP_SELECT_N == EBCC_CS_IDLE;
    endproperty
    a_end: assert property (p_end) else $error("ack did not end beat");
    property p_err; ACCESS_ERROR |-> RSP_VALID && RSP_ERROR; endproperty
    a_err: assert property (p_err) else $error("error pulse without answer");
    property p_mem;
        REQ_VALID && REQ_READY && REQ_TARGET[1] |=>
            (BYTE_LANE_STROBE_N == EBCC_STB_IDLE && CHIP_SELECT_N == EBCC_CS_IDLE) [*4];
    endproperty
    a_mem: assert property (p_mem) else $error("strobes on on-chip memory");
    property p_per;
        REQ_VALID && REQ_READY && REQ_TARGET == EBCC_TGT_PERIPH && !REQ_SDRAM |->
            ##[1:4] BYTE_LANE_STROBE_N != EBCC_STB_IDLE;
    endproperty
    a_per: assert property (p_per) else $error("no strobe for peripheral");
    c_err: cover property (ACCESS_ERROR);
    c_wait: cover property ((CHIP_SELECT_N != EBCC_CS_IDLE && CYCLE_DONE_ACK_N) [*5]);
    c_rd: cover property (!OUTPUT_ENABLE_N);
endmodule // ebcc_ctrl_sva

bind ebcc_ctrl ebcc_ctrl_sva ebcc_ctrl_sva_i (.*);

/* verif/ebcc_slave_model.sv */
// Behavioural model of an external memory slave answering bus beats.
`timescale 1ns/100ps
module ebcc_slave_model
    import ebcc_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] chip_select_n,
    input wire logic clr,
    input wire logic err_mode,
    input wire logic [3:0] wait_cycles,
    input wire logic [127:0] words,
    output logic cycle_done_ack_n,
    output logic cycle_error_ack_n,
    output logic [31:0] data_in
);
    // ==========================================================
    // Beat tracking.
    logic [3:0] cnt_reg;
    logic [1:0] beat_reg;
    logic sel_reg;
    logic [31:0] last_reg;
    logic sel;
    logic go;
    assign sel = chip_select_n != EBCC_CS_IDLE;
    assign go = sel && cnt_reg >= wait_cycles;
    // Acknowledge lets go with the select, so no stale ack leaks into the next beat.
    assign cycle_done_ack_n = !(go && !err_mode);
    assign cycle_error_ack_n = !(go && err_mode);
    // A released bus shows the inverse of the last word, never the old value.
    assign data_in = sel ? words[beat_reg * 32 +: 32] : ~last_reg;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 4'h0;
            beat_reg <= 2'h0;
            sel_reg <= 1'b0;
            last_reg <= 32'h0;
        end else begin
            cnt_reg <= sel ? cnt_reg + {3'h0, cnt_reg != 4'hf} : 4'h0;
            sel_reg <= sel;
            if (sel) begin
                last_reg <= data_in;
            end
            if (clr) begin
                beat_reg <= 2'h0;
            end else if (sel_reg && !sel) begin
                beat_reg <= beat_reg + 2'h1;
            end
        end
    end
endmodule // ebcc_slave_model

/* verif/testbench.sv */
// Self-checking testbench of the external bus cycle control block.
`timescale 1ns/100ps
module testbench
    import ebcc_pkg::*;
;
    // ==========================================================
    // Stimulus and monitors.
    logic mclk = 0, resetn = 0, req_valid = 0, req_read = 0, req_sdram = 0, width_load = 0;
    logic [1:0] req_size = 0, req_offset = 0, req_target = 0, width_code = 0;
    logic [1:0] size_pins = EBCC_W16;
    logic [2:0] req_cs = 0, width_cs = 0;
    logic [31:0] req_wdata = 0, data_in, data_out, rsp_rdata;
    logic req_ready, rsp_valid, rsp_error, access_error, data_oe, begin_n, oe_n, rw, sdram_write_strobe;
    logic done_n, err_n, err_mode = 0;
    logic [7:0] cs_n;
    logic [1:0] stb_n, last_stb;
    logic [3:0] wait_cycles = 0;
    logic [127:0] words = 0;
    logic [31:0] beat_dout [4];
    logic [1:0] beat_stb [4];
    logic [1:0] beat_dir [4];
    logic [1:0] beat_oe [4];
    int n_errors = 0, checks_done = 0, beats = 0;
    always #5 mclk = ~mclk;
    ebcc_ctrl ebcc_ctrl_i (.MCLK(mclk), .RESETN(resetn), .REQ_VALID(req_valid),
        .REQ_READ(req_read), .REQ_SIZE(req_size), .REQ_OFFSET(req_offset), .REQ_CS(req_cs),
        .REQ_TARGET(req_target), .REQ_SDRAM(req_sdram), .REQ_WDATA(req_wdata),
        .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_ERROR(rsp_error),
        .RSP_RDATA(rsp_rdata), .ACCESS_ERROR(access_error), .WIDTH_LOAD(width_load),
        .WIDTH_CS(width_cs), .WIDTH_CODE(width_code), .TRANSFER_SIZE_PINS(size_pins),
        .CYCLE_DONE_ACK_N(done_n), .CYCLE_ERROR_ACK_N(err_n), .DATA_IN(data_in),
        .DATA_OUT(data_out), .DATA_OE(data_oe), .TRANSFER_BEGIN_N(begin_n),
        .CHIP_SELECT_N(cs_n), .BYTE_LANE_STROBE_N(stb_n), .OUTPUT_ENABLE_N(oe_n),
        .READ_WRITE(rw), .SDRAM_WRITE_STROBE(sdram_write_strobe));
    ebcc_slave_model ebcc_slave_model_i (.mclk(mclk), .resetn(resetn), .chip_select_n(cs_n),
        .clr(req_valid), .err_mode(err_mode), .wait_cycles(wait_cycles), .words(words),
        .cycle_done_ack_n(done_n), .cycle_error_ack_n(err_n), .data_in(data_in));
    always @(negedge mclk) begin
        if (!begin_n && beats < 4) begin
            beat_dout[beats] = data_out;
            beat_stb[beats] = stb_n;
            beat_dir[beats] = {rw, sdram_write_strobe};
            beat_oe[beats] = {oe_n, data_oe};
            beats++;
        end
        if (stb_n != EBCC_STB_IDLE) begin
            last_stb = stb_n;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One whole access; the bench waits up to 100 cycles for ready, then requests whether or not ready is high.
    task automatic acc(input logic rd, input logic [1:0] sz, input logic [1:0] off,
            input logic [1:0] tgt, input logic [2:0] cs, input logic sd, input logic [31:0] wd);
        int i;
        i = 0;
        while (req_ready !== 1'b1 && i < 100) begin
            @(negedge mclk);
            i++;
        end
        beats = 0;
        last_stb = EBCC_STB_IDLE;
        {req_read, req_size, req_offset} = {rd, sz, off};
        {req_target, req_cs, req_sdram} = {tgt, cs, sd};
        req_wdata = wd;
        req_valid = 1'b1;
        @(negedge mclk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && i < 200) begin
            @(negedge mclk);
            i++;
        end
        // A pulse seen on the very last try still counts as an answer.
        if (rsp_valid !== 1'b1) begin
            n_errors++;
            end_sim();
        end
    endtask
    task automatic t_boot16;
        wait_cycles = 4'h3;
        words[63:0] = 64'h5566_7788_a1b2_c3d4;
        acc(1'b1, EBCC_W32, 2'h0, EBCC_TGT_EXT, 3'h0, 1'b0, 32'h0);
        chk(beats, 2);
        chk(rsp_rdata, 32'ha1b2_5566);
        chk(beat_stb[0], 2'h0);
        chk(beat_dir[0], 2'h3);
        chk(beat_oe[0], 2'h0);
        $display("boot width read done");
    endtask
    task automatic t_write8;
        width_cs = 3'h1;
        width_code = EBCC_W8;
        width_load = 1'b1;
        @(negedge mclk);
        width_load = 1'b0;
        wait_cycles = 4'h0;
        acc(1'b0, EBCC_W16, 2'h0, EBCC_TGT_EXT, 3'h1, 1'b0, 32'h1234);
        chk(beats, 2);
        chk(beat_dout[0][31:24], 8'h12);
        chk(beat_dout[1][31:24], 8'h34);
        chk(beat_stb[1], 2'h1);
        chk(beat_dir[1], 2'h1);
        chk(beat_oe[1], 2'h3);
        $display("narrow write done");
    endtask
    task automatic t_lanes;
        logic [1:0] lane;
        wait_cycles = 4'h6;
        words[31:0] = 32'h0102_0304;
        for (int i = 0; i < 8; i++) begin
            lane = 2'h3 - i[1:0];
            acc(i[2], EBCC_W8, i[1:0], EBCC_TGT_EXT, 3'h2, 1'b0, 32'h5a);
            chk(beat_stb[0], lane[0] ? 2'h1 : 2'h2);
            if (i[2]) begin
                chk(rsp_rdata, 32'h4 - lane);
            end else begin
                chk(beat_dout[0][lane * 8 +: 8], 8'h5a);
            end
        end
        $display("byte lane sweep done");
    endtask
    task automatic t_error;
        err_mode = 1'b1;
        acc(1'b1, EBCC_W32, 2'h0, EBCC_TGT_EXT, 3'h1, 1'b0, 32'h0);
        chk(access_error, 1'b1);
        chk(rsp_error, 1'b1);
        chk(beats, 1);
        err_mode = 1'b0;
        $display("error termination done");
    endtask
    task automatic t_sdram_onchip;
        acc(1'b0, EBCC_W8, 2'h0, EBCC_TGT_EXT, 3'h3, 1'b1, 32'h77);
        chk(beat_stb[0], 2'h2);
        chk(beat_dir[0], 2'h0);
        acc(1'b0, EBCC_W8, 2'h0, EBCC_TGT_PERIPH, 3'h3, 1'b0, 32'h77);
        chk(last_stb, 2'h1);
        chk(beats, 0);
        acc(1'b1, EBCC_W8, 2'h0, EBCC_TGT_ONCHIP, 3'h3, 1'b0, 32'h0);
        chk(last_stb, EBCC_STB_IDLE);
        chk(rsp_rdata, 32'h0);
        acc(1'b0, EBCC_W8, 2'h0, 2'h3, 3'h3, 1'b0, 32'h0);
        chk(last_stb, EBCC_STB_IDLE);
        $display("sdram and on-chip done");
    endtask
    initial begin
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        t_boot16();
        t_write8();
        t_lanes();
        t_error();
        t_sdram_onchip();
        end_sim();
    end
endmodule // testbench
